// >>> rtl/sleep_ctrl.sv
// sleep-mode clock gating and power enable controller with an APB slave
`timescale 1ns/100ps
module sleep_ctrl
	import sleep_ctrl_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              resetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	input  wire logic              sleep_exec,
	input  wire logic              brownout_enable_fuse,
	input  wire logic [WK_N-1:0]   wake_req,
	output clk_en_s                clk_en,
	output power_en_s              pwr_en,
	output logic                   core_resume,
	output logic                   conv_extended
);

	default clocking mclk_edge @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	// ******************************************************************
	// registers and bus
	// ******************************************************************
	logic [7:0]   ctrl;
	logic [3:0]   periph;
	sleep_state_e state;
	sleep_mode_e  cur_mode;
	logic [2:0]   wake_cnt;
	logic         conv_was_on;

	wire          acc     = psel && penable;
	wire          wr      = acc && pwrite;
	wire          hit_ctl = (paddr == ADDR_CTRL);
	wire          hit_per = (paddr == ADDR_PERIPH);
	wire          hit_st  = (paddr == ADDR_STATUS);
	wire          mapped  = hit_ctl || hit_per || hit_st;
	wire logic [31:0] rd_mux;
	assign rd_mux = hit_ctl ? {24'h000000, ctrl} :
		hit_per ? {28'h0000000, periph} :
		hit_st  ? {26'h0000000, conv_was_on, wake_cnt, state} :
		32'h00000000;

	wire sleep_mode_e sel_mode = sleep_mode_e'(ctrl[CTRL_MODE_LO +: 3]);
	wire          asel     = ctrl[CTRL_ASYNC];
	wire          xtal     = ctrl[CTRL_CRYSTAL];
	// reserved codes and standby without a crystal do not sleep at all
	wire          mode_ok  = (sel_mode == MODE_IDLE) ||
		(sel_mode == MODE_NOISE) || (sel_mode == MODE_PDOWN) ||
		(sel_mode == MODE_PSAVE) ||
		((sel_mode == MODE_STANDBY) && xtal);                   // see (R4) (R1)
	wire          go_sleep = (state == ST_RUN) && sleep_exec &&
		ctrl[CTRL_PERMIT] && mode_ok;                           // see (R2)
	wire          asleep   = (state == ST_SLEEP);

	// ******************************************************************
	// wake-up source gating
	// ******************************************************************
	wire          deep   = (cur_mode != MODE_IDLE);
	// edge-configured external pins never wake from the deeper modes
	wire          irq_ok = (wake_req[WK_IRQ0] &&
		(!deep || ctrl[CTRL_LVL0])) ||
		(wake_req[WK_IRQ1] && (!deep || ctrl[CTRL_LVL1]));       // see (R7)
	logic         wake_hit;
	always_comb begin
		wake_hit = 1'b0;
		case (cur_mode)                                              // see (R8)
			MODE_IDLE:    wake_hit = |wake_req;
			MODE_NOISE:   wake_hit = irq_ok || wake_req[WK_ADDR] ||
				(wake_req[WK_TMR2] && asel) || wake_req[WK_NVM] ||
				wake_req[WK_CONV];                                   // see (R6)
			MODE_PSAVE:   wake_hit = irq_ok || wake_req[WK_ADDR] ||
				(wake_req[WK_TMR2] && asel);                         // see (R6)
			default:      wake_hit = irq_ok || wake_req[WK_ADDR];
		endcase
	end

	// ******************************************************************
	// clock and power enables per mode
	// ******************************************************************
	clk_en_s      next_clk;
	power_en_s    next_pwr;
	wire          conv_on = periph[PER_CONV];
	wire          cmp_cfg = periph[PER_CMP];
	logic         cmp_live;
	always_comb begin
		next_clk = '{core: 1'b1, progmem: 1'b1, io: 1'b1, conv: 1'b1,
			async_t: asel};
		next_pwr.main_osc  = 1'b1;
		next_pwr.timer_osc = asel;
		cmp_live = cmp_cfg;
		if (asleep) begin
			next_clk.core    = 1'b0;
			next_clk.progmem = 1'b0;
			next_clk.io      = (cur_mode == MODE_IDLE);
			next_clk.conv    = (cur_mode == MODE_IDLE) ||
				(cur_mode == MODE_NOISE);
			next_clk.async_t = asel && ((cur_mode == MODE_IDLE) ||
				(cur_mode == MODE_NOISE) ||
				(cur_mode == MODE_PSAVE));                  // see (R3) (R6)
			next_pwr.timer_osc = next_clk.async_t;           // see (R6)
			next_pwr.main_osc  = (cur_mode == MODE_IDLE) ||
				(cur_mode == MODE_NOISE) ||
				(cur_mode == MODE_STANDBY);                  // see (R4)
			cmp_live = cmp_cfg && ((cur_mode == MODE_IDLE) ||
				(cur_mode == MODE_NOISE));                   // see (R13)
		end
		next_pwr.conv  = conv_on;                            // see (R9)
		next_pwr.cmp   = cmp_live;
		next_pwr.bod   = brownout_enable_fuse;               // see (R15)
		next_pwr.wdog  = periph[PER_WDOG];                   // see (R16)
		// a comparator on the reference keeps it alive even when auto-off
		next_pwr.vref  = brownout_enable_fuse || conv_on ||
			cmp_live || (cmp_cfg && periph[PER_CMPREF]);   // see (R17) (R14)
		next_pwr.inbuf = next_clk.io || next_clk.conv;       // see (R19)
	end

	// ******************************************************************
	// sequencing
	// ******************************************************************
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state    <= ST_RUN;
			cur_mode <= MODE_IDLE;
			wake_cnt <= 3'h0;
		end else begin
			case (state)
				ST_RUN: begin
					if (go_sleep) begin
						state    <= ST_SLEEP;
						cur_mode <= sel_mode;
					end
				end
				ST_SLEEP: begin
					if (wake_hit) begin
						if (cur_mode == MODE_STANDBY) begin
							state    <= ST_WAKE;
							// the load edge and the final zero edge both
							// count, so resume shows on the sixth edge
							wake_cnt <= 3'(STANDBY_WAKE_CYCLES - 2); // see (R5)
						end else begin
							state <= ST_RUN;
						end
					end
				end
				ST_WAKE: begin
					if (wake_cnt == 3'h0) begin
						state <= ST_RUN;
					end else begin
						wake_cnt <= wake_cnt - 3'h1;                 // see (R5)
					end
				end
				default: state <= ST_RUN;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ctrl   <= CTRL_RESET;
			periph <= PER_RESET;
		end else if (wr && hit_ctl) begin
			ctrl <= pwdata[7:0];
		end else if (wr && hit_per) begin
			periph <= pwdata[3:0];
		end
	end

	// extended flag: set on converter re-enable, cleared while software
	// holds the converter bit low; the first enable after reset counts too
	wire conv_rise = conv_on && !conv_was_on;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			conv_was_on   <= 1'b0;
			conv_extended <= 1'b0;
		end else begin
			conv_was_on <= conv_on;
			if (conv_rise) begin
				conv_extended <= 1'b1;                              // see (R10)
			end else if (!conv_on) begin
				conv_extended <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pready      <= 1'b0;
			prdata      <= 32'h00000000;
			pslverr     <= 1'b0;
			clk_en      <= '{default: 1'b1};
			pwr_en      <= '{main_osc: 1'b1, default: 1'b0};
			core_resume <= 1'b0;
		end else begin
			pready      <= psel && !penable;
			prdata      <= rd_mux;
			pslverr     <= psel && !penable && !mapped;
			clk_en      <= next_clk;
			pwr_en      <= next_pwr;
			core_resume <= ((state == ST_WAKE) && (wake_cnt == 3'h0)) ||
				(asleep && wake_hit && (cur_mode != MODE_STANDBY));
		end
	end

	// ******************************************************************
	// checks
	// ******************************************************************
	// attempts also start at the edge where reset lifts, so a consequent
	// that reads an output must also hold for that output's reset value
	a_standby_wake_delay: assert property ( // see (R5)
		(asleep && wake_hit && cur_mode == MODE_STANDBY) |-> ##6 core_resume)
		else $error("standby wake not after six cycles");
	a_standby_quiet: assert property ( // see (R5)
		(asleep && wake_hit && cur_mode == MODE_STANDBY) |=>
		!core_resume [*5])
		else $error("standby resumed early");
	a_permit_needed: assert property ( // see (R2)
		(state == ST_RUN && sleep_exec && !ctrl[CTRL_PERMIT]) |=>
		state == ST_RUN)
		else $error("sleep without permit");
	a_reserved_refused: assert property ( // see (R1)
		(state == ST_RUN && sleep_exec && !mode_ok) |=> state == ST_RUN)
		else $error("refused mode entered sleep");
	a_standby_crystal: assert property ( // see (R4)
		(go_sleep && sel_mode == MODE_STANDBY) |-> xtal)
		else $error("standby without crystal");
	a_edge_no_wake: assert property ( // see (R7)
		(asleep && deep && wake_req == (WK_N)'(1) && !ctrl[CTRL_LVL0])
		|=> asleep)
		else $error("edge irq woke deep sleep");
	a_level_wake: assert property ( // see (R7)
		(asleep && deep && wake_req[WK_IRQ1] && ctrl[CTRL_LVL1])
		|=> !asleep)
		else $error("level irq did not wake");
	a_wake_sources: assert property ( // see (R8)
		(asleep && cur_mode == MODE_PDOWN && wake_req[WK_OTHER] &&
		!irq_ok && !wake_req[WK_ADDR]) |=> asleep)
		else $error("illegal power-down wake");
	a_idle_wake_any: assert property ( // see (R8)
		(asleep && cur_mode == MODE_IDLE && |wake_req) |=>
		core_resume && state == ST_RUN)
		else $error("idle ignored a wake source");
	a_noise_wake: assert property ( // see (R8)
		(asleep && cur_mode == MODE_NOISE && wake_req[WK_NVM]) |=> !asleep)
		else $error("noise mode ignored memory ready");
	a_pdown_wake_addr: assert property ( // see (R8)
		(asleep && cur_mode == MODE_PDOWN && wake_req[WK_ADDR]) |=>
		core_resume && state == ST_RUN)
		else $error("power-down ignored address match");
	a_standby_no_conv: assert property ( // see (R8)
		(asleep && cur_mode == MODE_STANDBY &&
		wake_req == (WK_N)'(1 << WK_CONV)) |=> asleep)
		else $error("converter woke standby");

	// ******************************************************************
	// clock and power checks
	// ******************************************************************
	a_psave_clocks: assert property ( // see (R3) (R6)
		(asleep && cur_mode == MODE_PSAVE) |=> !clk_en.io && !clk_en.conv &&
		!clk_en.core && (clk_en.async_t == asel))
		else $error("power-save clocks wrong");
	a_psave_osc: assert property ( // see (R3) (R6)
		(asleep && cur_mode == MODE_PSAVE) |=> !pwr_en.main_osc &&
		(pwr_en.timer_osc == $past(asel)))
		else $error("power-save oscillators wrong");
	a_idle_clocks: assert property ( // see (R6)
		(asleep && cur_mode == MODE_IDLE) |=> !clk_en.core &&
		!clk_en.progmem && clk_en.io && clk_en.conv &&
		(clk_en.async_t == $past(asel)))
		else $error("idle clocks wrong");
	a_idle_osc: assert property ( // see (R6)
		(asleep && cur_mode == MODE_IDLE) |=> pwr_en.main_osc &&
		(pwr_en.timer_osc == $past(asel)))
		else $error("idle oscillators wrong");
	a_noise_clocks: assert property ( // see (R6)
		(asleep && cur_mode == MODE_NOISE) |=> !clk_en.core &&
		!clk_en.io && clk_en.conv && (clk_en.async_t == $past(asel)))
		else $error("noise mode clocks wrong");
	a_noise_osc: assert property ( // see (R6)
		(asleep && cur_mode == MODE_NOISE) |=> pwr_en.main_osc &&
		(pwr_en.timer_osc == $past(asel)))
		else $error("noise mode oscillators wrong");
	// the run-state async clock enable resets high, so only the
	// oscillator enable is checked against the select bit here
	a_async_gate: assert property ( // see (R6)
		!asel |=> !pwr_en.timer_osc)
		else $error("timer oscillator on without select");
	a_pdown_osc: assert property ( // see (R4)
		(asleep && cur_mode == MODE_PDOWN) |=> !pwr_en.main_osc &&
		!pwr_en.timer_osc && !clk_en.async_t)
		else $error("power-down oscillators wrong");
	a_standby_osc: assert property ( // see (R4)
		(asleep && cur_mode == MODE_STANDBY) |=> pwr_en.main_osc &&
		!pwr_en.timer_osc && !clk_en.core && !clk_en.io &&
		!clk_en.conv && !clk_en.async_t)
		else $error("standby oscillators wrong");
	a_cmp_auto_off: assert property ( // see (R13)
		(asleep && cur_mode inside {MODE_PDOWN, MODE_PSAVE, MODE_STANDBY})
		|=> !pwr_en.cmp)
		else $error("comparator left on");
	a_cmp_kept: assert property ( // see (R13)
		(asleep && cur_mode inside {MODE_IDLE, MODE_NOISE}) |=>
		pwr_en.cmp == $past(cmp_cfg))
		else $error("comparator changed in light sleep");
	a_conv_kept: assert property ( // see (R9)
		conv_on |=> pwr_en.conv)
		else $error("converter switched off");
	a_keep_bod_wdog: assert property ( // see (R15) (R16)
		1'b1 |=> (pwr_en.bod == $past(brownout_enable_fuse)) &&
		(pwr_en.wdog == $past(periph[PER_WDOG])))
		else $error("bod or watchdog dropped");
	a_vref_need: assert property ( // see (R17) (R14)
		(!brownout_enable_fuse && !conv_on && !cmp_cfg) |=> !pwr_en.vref)
		else $error("reference on without need");
	a_vref_cmpref: assert property ( // see (R14)
		(cmp_cfg && periph[PER_CMPREF]) |=> pwr_en.vref)
		else $error("reference dropped under comparator");
	a_inbuf_off: assert property ( // see (R19)
		(asleep && deep && cur_mode != MODE_NOISE) |=> !pwr_en.inbuf)
		else $error("input buffers left on");
	a_extended: assert property ( // see (R10)
		conv_rise |=> conv_extended)
		else $error("no extended conversion");
	a_extended_clear: assert property ( // see (R10)
		!conv_on |=> !conv_extended)
		else $error("extended flag kept with converter off");

	c_standby: cover property (state == ST_WAKE ##1 state == ST_WAKE);
	c_psave: cover property (asleep && cur_mode == MODE_PSAVE && wake_hit);
	c_idle: cover property (go_sleep && sel_mode == MODE_IDLE);
	c_noise: cover property (asleep && cur_mode == MODE_NOISE && wake_hit);
	c_level: cover property (asleep && deep && irq_ok);

endmodule // sleep_ctrl

// >>> rtl/sleep_ctrl_pkg.sv
// package: register map, mode codes and timing for the sleep controller
// Notes on behaviour
// (R1) mode field: 000 idle, 001 noise-red, 010 pwr-down, 011 pwr-save, 110 standby
// (R2) core sleeps only if permit bit is one when sleep executes
// (R3) power-save stops all clocks except the async timer clock
// (R4) standby needs code 110 and crystal option; main oscillator keeps running
// (R5) standby wake-up resumes execution after 6 clock cycles
// (R6) async clock and timer oscillator only run when async select is set; the async clock enable resets high regardless
// (R7) external irq pins wake from deep modes only when level-configured
// (R8) per-mode wake-up source sets as tabulated
// (R9) an enabled converter stays enabled in every sleep mode
// (R10) converter re-enabled after off makes next conversion extended
// (R11) software should disable converter before sleep
// (R12) software should disable comparator before noise-red or unneeded idle
// (R13) comparator disabled automatically outside idle and noise-reduction
// (R14) reference stays on for a comparator using it, unless comparator off
// (R15) fuse-enabled brown-out detector runs in every sleep mode
// (R16) an enabled watchdog keeps running in every sleep mode
// (R17) reference enabled only while brown-out, comparator or converter needs it
// (R18) software waits reference start-up unless it stayed on
// (R19) input buffers off when io and converter clocks both stop
// (R20) software should set pins for minimum power before sleep
package sleep_ctrl_pkg;

	typedef enum logic [2:0] {
		MODE_IDLE    = 3'b000,
		MODE_NOISE   = 3'b001,
		MODE_PDOWN   = 3'b010,
		MODE_PSAVE   = 3'b011,
		MODE_RSVD4   = 3'b100,
		MODE_RSVD5   = 3'b101,
		MODE_STANDBY = 3'b110,
		MODE_RSVD7   = 3'b111
	} sleep_mode_e;

	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_SLEEP = 2'b01,
		ST_WAKE  = 2'b10
	} sleep_state_e;

	// register byte addresses
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_PERIPH = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;

	// control register fields
	localparam int CTRL_PERMIT   = 0;
	localparam int CTRL_MODE_LO  = 1;
	localparam int CTRL_CRYSTAL  = 4;
	localparam int CTRL_ASYNC    = 5;
	localparam int CTRL_LVL0     = 6;
	localparam int CTRL_LVL1     = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// peripheral register fields
	localparam int PER_CONV   = 0;
	localparam int PER_CMP    = 1;
	localparam int PER_CMPREF = 2;
	localparam int PER_WDOG   = 3;
	localparam logic [3:0] PER_RESET = 4'h0;

	// wake-up source index
	localparam int WK_IRQ0  = 0;
	localparam int WK_IRQ1  = 1;
	localparam int WK_ADDR  = 2;
	localparam int WK_TMR2  = 3;
	localparam int WK_NVM   = 4;
	localparam int WK_CONV  = 5;
	localparam int WK_OTHER = 6;
	localparam int WK_N     = 7;

	localparam int STANDBY_WAKE_CYCLES = 6;
	localparam int CLK_HZ = 50_000_000;

	typedef struct packed {
		logic core;
		logic progmem;
		logic io;
		logic conv;
		logic async_t;
	} clk_en_s;

	typedef struct packed {
		logic main_osc;
		logic timer_osc;
		logic conv;
		logic cmp;
		logic vref;
		logic bod;
		logic wdog;
		logic inbuf;
	} power_en_s;

endpackage

// >>> testbench/core_model.sv
// core model: issues the sleep instruction on request of the bench
`timescale 1ns/100ps
module core_model (
	input  wire logic mclk,
	input  wire logic resetn,
	input  wire logic go,
	output logic      sleep_exec
);
	// the bench writes the permit bit just before each request
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			sleep_exec <= 1'b0;
		else
			sleep_exec <= go;
	end
endmodule // core_model

// >>> testbench/sleep_ctrl_tb.sv
// testbench for the sleep controller: apb access, sleep entry and wake-up
`timescale 1ns/100ps
module sleep_ctrl_tb
	import sleep_ctrl_pkg::*;
;
	logic            mclk, resetn, psel, penable, pwrite, go, fuse;
	logic [11:0]     paddr;
	logic [31:0]     pwdata, rd, prdata;
	logic [WK_N-1:0] wake_req;
	logic            pready, pslverr, sleep_exec, core_resume, conv_ext;
	logic            err, cur_async;
	clk_en_s         clk_en;
	power_en_s       pwr_en;
	logic [31:0]     bad [5];
	int              mismatches, checked;

	sleep_ctrl sleep_ctrl_inst (.mclk(mclk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .sleep_exec(sleep_exec),
		.brownout_enable_fuse(fuse), .wake_req(wake_req),
		.clk_en(clk_en), .pwr_en(pwr_en), .core_resume(core_resume),
		.conv_extended(conv_ext));
	core_model core_model_inst (.mclk(mclk), .resetn(resetn), .go(go),
		.sleep_exec(sleep_exec));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// wait state count is not assumed; the bound only stops a hang
	task automatic apb(input logic wr, input logic [11:0] a,
			input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk({31'h0, pready}, 32'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [31:0] ctl(input logic [2:0] m,
			input logic x, input logic a, input logic l);
		return {24'h0, l, l, a, x, m, 1'b1};
	endfunction

	task automatic enter(input logic [31:0] c, input logic [4:0] ec,
			input logic [7:0] ep);
		cur_async = c[CTRL_ASYNC];
		apb(1'b1, ADDR_CTRL, c);
		@(posedge mclk);
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		repeat (4) @(posedge mclk);
		#1;
		chk({27'h0, clk_en}, {27'h0, ec});
		chk({24'h0, pwr_en}, {24'h0, ep});
	endtask

	// exp 0: the source must not wake; otherwise cycles until resume
	task automatic wake(input int i, input int exp);
		int n;
		n = 0;
		@(posedge mclk);
		wake_req <= (WK_N)'(1 << i);
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (core_resume !== 1'b1 && n < 20);
		chk(n, (exp == 0) ? 20 : exp);
		@(posedge mclk);
		wake_req <= '0;
		if (exp != 0) begin
			repeat (3) @(posedge mclk);
			#1;
			chk({27'h0, clk_en}, {27'h0, 4'hF, cur_async});
		end
	endtask

	initial begin
		#100000;
		mismatches++;
		report_and_stop();
	end

	initial begin
		{resetn, psel, penable, pwrite, go, fuse, cur_async} = '0;
		paddr = '0;
		pwdata = '0;
		wake_req = '0;
		mismatches = 0;
		checked = 0;
		bad = '{ctl(MODE_STANDBY, 0, 0, 0), ctl(MODE_RSVD4, 1, 0, 0),
			ctl(MODE_RSVD5, 1, 0, 0), ctl(MODE_RSVD7, 1, 0, 0),
			ctl(MODE_IDLE, 0, 0, 0) & 32'hFFFF_FFFE};
		repeat (16) @(posedge mclk);
		resetn <= 1'b1;
		#1;
		chk({27'h0, clk_en}, 32'h1F);
		chk({24'h0, pwr_en}, 32'h80);
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk(rd, {24'h0, CTRL_RESET});
		apb(1'b0, 12'h00C, 32'h0);
		chk({31'h0, err}, 32'h1);
		$display("test reset done");
		apb(1'b1, ADDR_PERIPH, 32'h1);
		repeat (2) @(posedge mclk);
		#1;
		chk({31'h0, conv_ext}, 32'h1);
		chk({31'h0, pwr_en.vref}, 32'h1);
		apb(1'b1, ADDR_PERIPH, 32'h0);
		repeat (2) @(posedge mclk);
		#1;
		chk({31'h0, conv_ext}, 32'h0);
		chk({31'h0, pwr_en.vref}, 32'h0);
		$display("test converter done");
		// refused entries leave the run clocks, async clock off, buffers on
		for (int k = 0; k < 5; k++)
			enter(bad[k], 5'h1E, 8'h81);
		$display("test refused done");
		// comparator stays off for the lighter modes
		enter(ctl(MODE_IDLE, 0, 1, 0), 5'b00111, 8'hC1);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd[1:0], 32'h1);
		wake(WK_OTHER, 1);
		enter(ctl(MODE_NOISE, 0, 0, 0), 5'b00010, 8'h81);
		wake(WK_OTHER, 0);
		wake(WK_TMR2, 0);
		wake(WK_NVM, 1);
		@(posedge mclk);
		fuse <= 1'b1;
		apb(1'b1, ADDR_PERIPH, 32'hF);
		enter(ctl(MODE_PDOWN, 0, 0, 0), 5'b00000, 8'h2E);
		wake(WK_IRQ0, 0);
		wake(WK_OTHER, 0);
		wake(WK_ADDR, 1);
		@(posedge mclk);
		fuse <= 1'b0;
		apb(1'b1, ADDR_PERIPH, 32'h0);
		enter(ctl(MODE_PDOWN, 0, 0, 1), 5'b00000, 8'h00);
		wake(WK_IRQ1, 1);
		enter(ctl(MODE_PSAVE, 0, 1, 0), 5'b00001, 8'h40);
		wake(WK_TMR2, 1);
		enter(ctl(MODE_PSAVE, 0, 0, 0), 5'b00000, 8'h00);
		wake(WK_TMR2, 0);
		wake(WK_ADDR, 1);
		enter(ctl(MODE_STANDBY, 1, 0, 0), 5'b00000, 8'h80);
		wake(WK_CONV, 0);
		wake(WK_ADDR, STANDBY_WAKE_CYCLES);
		$display("test modes done");
		report_and_stop();
	end
endmodule // sleep_ctrl_tb
